/* bridge_model.sv */
// model of the bridge that drives the register interface
`timescale 1ns/100ps
`default_nettype none
module bridge_model (
  input wire logic mclk,
  output logic [15:0] reg_word_addr,
  output logic [31:0] reg_wr_data,
  output logic [3:0] reg_byte_write_mask,
  output logic reg_write_strobe,
  output logic reg_read_request,
  input wire logic [31:0] reg_rd_data,
  input wire logic reg_read_valid
);
  initial begin
    reg_word_addr = 16'hFFFF;
    reg_wr_data = 32'h0000_0000;
    reg_byte_write_mask = 4'h0;
    reg_write_strobe = 1'b0;
    reg_read_request = 1'b0;
  end
  // mask left clear: a whole-word write must not depend on it
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_write_strobe <= 1'b1;
    reg_word_addr <= a;
    reg_wr_data <= d;
    @(posedge mclk);
    reg_write_strobe <= 1'b0;
    reg_word_addr <= ~a;
    reg_wr_data <= ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d,
    output int lat);
    @(posedge mclk);
    reg_read_request <= 1'b1;
    reg_word_addr <= a;
    @(posedge mclk);
    reg_read_request <= 1'b0;
    lat = 0;
    while (reg_read_valid !== 1'b1 && lat < 8) begin
      @(posedge mclk);
      lat++;
    end
    d = reg_rd_data;
    reg_word_addr <= ~a;
  endtask
endmodule
`default_nettype wire

/* tb.sv */
// testbench for the user register block
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic mclk, reset_n, reg_write_strobe, reg_read_request, reg_read_valid;
  logic [15:0] reg_word_addr;
  logic [31:0] reg_wr_data, reg_rd_data, d;
  logic [3:0] reg_byte_write_mask;
  logic [2:0] main_user_cmd_code, c;
  logic single_cmd_request, read_gen_start, main_user_busy_flag;
  logic main_user_error_flag, read_gen_busy, read_gen_check_fail;
  logic [10:0] identify_ram_addr;
  user_reg_pkg::gen_cfg_s read_gen_cfg;
  user_reg_pkg::sub_req_s write_gen_req, custom_ram_req;
  user_reg_pkg::sub_req_s custom_param_req, shared_req;
  int n_mismatch, num_checks, lat;
  logic [15:0] ta [9] = '{16'h0104, 16'h0300, 16'h2010, 16'h4008,
    16'h6000, 16'h8000, 16'hFFFC, 16'h1000, 16'h0018};
  logic [31:0] te [9] = '{32'h0104_AAAA, 32'h0300_BBBB, 32'h0000_0004,
    32'h4000_CCCC, 32'h6000_DDDD, 32'h8000_EEEE, 32'h8000_EEEE,
    32'h0000_0000, 32'h0000_0000};
  user_register_block user_register_block_inst (.mclk(mclk),
    .reset_n(reset_n), .reg_word_addr(reg_word_addr),
    .reg_wr_data(reg_wr_data), .reg_byte_write_mask(reg_byte_write_mask),
    .reg_write_strobe(reg_write_strobe),
    .reg_read_request(reg_read_request), .reg_rd_data(reg_rd_data),
    .reg_read_valid(reg_read_valid), .main_user_cmd_code(main_user_cmd_code),
    .single_cmd_request(single_cmd_request),
    .main_user_busy_flag(main_user_busy_flag),
    .main_user_error_flag(main_user_error_flag),
    .read_gen_cfg(read_gen_cfg), .read_gen_start(read_gen_start),
    .read_gen_busy(read_gen_busy), .read_gen_check_fail(read_gen_check_fail),
    .read_gen_rd_data(32'h0104_AAAA), .write_gen_req(write_gen_req),
    .write_gen_rd_data(32'h0300_BBBB), .identify_ram_addr(identify_ram_addr),
    .identify_ram_rd_data({21'h0, identify_ram_addr}),
    .custom_ram_req(custom_ram_req), .custom_ram_rd_data(32'h4000_CCCC),
    .custom_param_req(custom_param_req),
    .custom_param_rd_data(32'h6000_DDDD), .shared_req(shared_req),
    .shared_rd_data(32'h8000_EEEE));
  bridge_model bridge_model_inst (.mclk(mclk), .reg_word_addr(reg_word_addr),
    .reg_wr_data(reg_wr_data), .reg_byte_write_mask(reg_byte_write_mask),
    .reg_write_strobe(reg_write_strobe),
    .reg_read_request(reg_read_request), .reg_rd_data(reg_rd_data),
    .reg_read_valid(reg_read_valid));
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // a hung read loop is bounded, so this only trips on a stuck run
  initial begin
    #20000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    reset_n = 1'b0;
    {read_gen_busy, read_gen_check_fail} = 2'b00;
    {main_user_error_flag, main_user_busy_flag} = 2'b00;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    #1 check(read_gen_cfg.rate, 48'h64);
    bridge_model_inst.wr(user_reg_pkg::OFS_ADDR_LOW, 32'hDEAD_BEEF);
    bridge_model_inst.wr(user_reg_pkg::OFS_ADDR_HIGH, 32'hFFFF_1234);
    bridge_model_inst.wr(user_reg_pkg::OFS_LEN_LOW, 32'h0000_0001);
    bridge_model_inst.wr(user_reg_pkg::OFS_LEN_HIGH, 32'h5A5A_8001);
    #1 check(read_gen_cfg.start_addr, 48'h1234_DEAD_BEEF);
    check(read_gen_cfg.length, 48'h8001_0000_0001);
    for (int i = 0; i < 5; i++) begin
      d = {27'h0, i[0], ~i[0], i[2:0]};
      bridge_model_inst.wr(user_reg_pkg::OFS_PATT, d);
      #1 check({read_gen_cfg.random_addr, read_gen_cfg.check_en,
        read_gen_cfg.pattern}, d[4:0]);
    end
    bridge_model_inst.wr(user_reg_pkg::OFS_RATE, 32'h0000_0001);
    #1 check(read_gen_cfg.rate, 48'h01);
    bridge_model_inst.wr(user_reg_pkg::OFS_RATE, 32'hFFFF_FF64);
    #1 check(read_gen_cfg.rate, 48'h64);
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      bridge_model_inst.wr(user_reg_pkg::OFS_CMD, {29'h1FFF_FFFF, c});
      #1 check({single_cmd_request, read_gen_start, main_user_cmd_code},
        {c != 3'h3, c == 3'h3, c});
      @(posedge mclk);
      #1 check({single_cmd_request, read_gen_start}, 48'h0);
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      {read_gen_busy, read_gen_check_fail, main_user_error_flag,
        main_user_busy_flag} <= 4'h1 << i;
      bridge_model_inst.rd(user_reg_pkg::OFS_STATUS, d, lat);
      check(d[3:0], 48'h1 << i);
      check(lat, 48'h3);
    end
    for (int i = 0; i < 9; i++) begin
      bridge_model_inst.rd(ta[i], d, lat);
      check(d, te[i]);
    end
    bridge_model_inst.wr(16'h4008, 32'h1357_9BDF);
    #1 check({custom_ram_req.wr, custom_ram_req.data},
      {1'b1, 32'h1357_9BDF});
    bridge_model_inst.wr(16'h0300, 32'h2468_ACE0);
    #1 check({write_gen_req.wr, write_gen_req.addr}, {1'b1, 16'h0300});
    bridge_model_inst.wr(16'h1000, 32'hFFFF_FFFF);
    #1 check({write_gen_req.wr, custom_ram_req.wr, custom_param_req.wr,
      shared_req.wr}, 48'h0);
    end_of_test();
  end
endmodule
bind user_register_block user_reg_monitor user_reg_monitor_inst (
  .mclk(mclk), .reset_n(reset_n), .reg_word_addr(reg_word_addr),
  .reg_wr_data(reg_wr_data), .reg_write_strobe(reg_write_strobe),
  .reg_read_request(reg_read_request), .reg_rd_data(reg_rd_data),
  .reg_read_valid(reg_read_valid), .main_user_cmd_code(main_user_cmd_code),
  .single_cmd_request(single_cmd_request),
  .main_user_busy_flag(main_user_busy_flag),
  .main_user_error_flag(main_user_error_flag), .read_gen_cfg(read_gen_cfg),
  .read_gen_start(read_gen_start), .read_gen_busy(read_gen_busy),
  .read_gen_check_fail(read_gen_check_fail));
`default_nettype wire

/* user_reg_monitor.sv */
// assertion checker on the ports of the user register block
`timescale 1ns/100ps
`default_nettype none
module user_reg_monitor (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [15:0] reg_word_addr,
  input wire logic [31:0] reg_wr_data,
  input wire logic reg_write_strobe,
  input wire logic reg_read_request,
  input wire logic [31:0] reg_rd_data,
  input wire logic reg_read_valid,
  input wire logic [2:0] main_user_cmd_code,
  input wire logic single_cmd_request,
  input wire logic main_user_busy_flag,
  input wire logic main_user_error_flag,
  input wire user_reg_pkg::gen_cfg_s read_gen_cfg,
  input wire logic read_gen_start,
  input wire logic read_gen_busy,
  input wire logic read_gen_check_fail
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic wr_cmd;
  logic [3:0] sts;
  assign wr_cmd = reg_write_strobe && reg_word_addr == user_reg_pkg::OFS_CMD;
  assign sts = {read_gen_busy, read_gen_check_fail, main_user_error_flag,
    main_user_busy_flag};
  chk_read_valid_delay: assert property (
    reg_read_request |-> ##3 reg_read_valid ##1 !reg_read_valid)
    else $error("read valid not three cycles after request");
  chk_valid_has_cause: assert property (
    reg_read_valid |-> $past(reg_read_request, 3))
    else $error("read valid without request");
  chk_read_start: assert property (
    wr_cmd && reg_wr_data[2:0] == 3'h3 |=>
    read_gen_start && !single_cmd_request ##1 !read_gen_start)
    else $error("read command start pulse wrong");
  chk_single_request: assert property (
    wr_cmd && reg_wr_data[2:0] != 3'h3 |=> single_cmd_request &&
    !read_gen_start && main_user_cmd_code == $past(reg_wr_data[2:0]))
    else $error("single command request wrong");
  chk_pulse_cause: assert property (
    single_cmd_request || read_gen_start |-> $past(wr_cmd))
    else $error("command pulse without command write");
  chk_addr_high_word: assert property (
    reg_write_strobe && reg_word_addr == user_reg_pkg::OFS_ADDR_HIGH |=>
    read_gen_cfg.start_addr[47:32] == $past(reg_wr_data[15:0]))
    else $error("start address upper bits wrong");
  chk_length_low: assert property (
    reg_write_strobe && reg_word_addr == user_reg_pkg::OFS_LEN_LOW |=>
    read_gen_cfg.length[31:0] == $past(reg_wr_data))
    else $error("length low word wrong");
  chk_pattern_fields: assert property (
    reg_write_strobe && reg_word_addr == user_reg_pkg::OFS_PATT |=>
    {read_gen_cfg.random_addr, read_gen_cfg.check_en,
    read_gen_cfg.pattern} == $past(reg_wr_data[4:0]))
    else $error("pattern fields wrong");
  chk_status_bits: assert property (
    reg_read_valid && $past(reg_word_addr, 3) == user_reg_pkg::OFS_STATUS
    |-> reg_rd_data[3:0] == $past(sts, 3))
    else $error("status bits wrong");
  chk_ctrl_read_zero: assert property (
    reg_read_valid && $past(reg_word_addr, 3) <= user_reg_pkg::MAIN_CTRL_HI
    |-> reg_rd_data == 32'h0000_0000)
    else $error("write-only area read not zero");
  cover property (read_gen_start);
  cover property (single_cmd_request);
  cover property (reg_read_valid && reg_rd_data != 32'h0000_0000);
endmodule
`default_nettype wire

/* user_reg_pkg.sv */
// package: address map, field layout and encodings of the user register block
package user_reg_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // area bases and limits (word address units as carried on reg_word_addr)
  localparam logic [15:0] MAIN_CTRL_LO = 16'h0000;
  localparam logic [15:0] MAIN_CTRL_HI = 16'h00FF;
  localparam logic [15:0] MAIN_STS_LO = 16'h0100;
  localparam logic [15:0] MAIN_STS_HI = 16'h01FF;
  localparam logic [15:0] SUB_LO = 16'h0200;
  localparam logic [15:0] SUB_HI = 16'h03FF;
  localparam logic [15:0] IDEN_LO = 16'h2000;
  localparam logic [15:0] IDEN_HI = 16'h3FFF;
  localparam logic [15:0] CUST_LO = 16'h4000;
  localparam logic [15:0] CUST_HI = 16'h5FFF;
  localparam logic [15:0] CPARAM_LO = 16'h6000;
  localparam logic [15:0] CPARAM_HI = 16'h7FFF;
  localparam logic [15:0] SHARED_LO = 16'h8000;

  // register offsets
  localparam logic [15:0] OFS_ADDR_LOW = 16'h0000;
  localparam logic [15:0] OFS_ADDR_HIGH = 16'h0004;
  localparam logic [15:0] OFS_LEN_LOW = 16'h0008;
  localparam logic [15:0] OFS_LEN_HIGH = 16'h000C;
  localparam logic [15:0] OFS_CMD = 16'h0010;
  localparam logic [15:0] OFS_PATT = 16'h0014;
  localparam logic [15:0] OFS_RATE = 16'h0018;
  localparam logic [15:0] OFS_STATUS = 16'h0100;

  // field positions
  localparam int HIGH_W = 16;
  localparam int CMD_W = 3;
  localparam int PATT_W = 3;
  localparam int PATT_CHECK_BIT = 3;
  localparam int PATT_RANDOM_BIT = 4;
  localparam int RATE_W = 7;
  localparam int STS_BUSY_BIT = 0;
  localparam int STS_ERROR_BIT = 1;
  localparam int STS_FAIL_BIT = 2;
  localparam int STS_GEN_BUSY_BIT = 3;

  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [6:0] RST_RATE = 7'h64;

  // read pipeline depth
  localparam int READ_LATENCY = 3;

  typedef enum logic [2:0] {
    CMD_IDENTIFY = 3'h0,
    CMD_SHUTDOWN = 3'h1,
    CMD_RSVD2 = 3'h2,
    CMD_READ = 3'h3,
    CMD_HEALTH_LOG = 3'h4,
    CMD_RSVD5 = 3'h5,
    CMD_FLUSH = 3'h6,
    CMD_RSVD7 = 3'h7
  } cmd_e;

  typedef enum logic [2:0] {
    PATT_INCR = 3'h0,
    PATT_DECR = 3'h1,
    PATT_ZEROS = 3'h2,
    PATT_ONES = 3'h3,
    PATT_LFSR = 3'h4
  } patt_e;

  // settings toward the read test generator
  typedef struct packed {
    logic [47:0] start_addr;
    logic [47:0] length;
    logic [2:0] pattern;
    logic check_en;
    logic random_addr;
    logic [6:0] rate;
  } gen_cfg_s;

  // write/read request toward a submodule area
  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] data;
    logic wr;
    logic rd;
  } sub_req_s;

endpackage

/* user_register_block.sv */
// user register file: decoder, control registers and three-cycle read mux
//
// Summary of operation
// [R1] 0x0000-01FF main user, 0x0200-03FF secondary
// [R2] 0x2000-3FFF identify RAM, read only
// [R3] 0x4000-5FFF custom RAM, read and write
// [R4] 0x6000 custom params, 0x8000 shared area
// [R5] upper address bits select active unit
// [R6] byte mask ignored, whole word written
// [R7] low bits to submodule, upper bits mux; write_gen_req gets the whole address
// [R8] read valid is request delayed three flops
// [R9] 0x00xx write-only control, 0x01xx read-only status
// [R10] start address 48 bits from 0x0000/0x0004
// [R11] length 48 bits from 0x0008/0x000C
// [R12] command codes: identify shutdown read log flush
// [R13] non-read command pulses single request
// [R14] read command pulses generator start flag
// [R15] pattern select incr decr zeros ones lfsr
// [R16] pattern bit 3 enables data checking
// [R17] pattern bit 4 selects random addressing
// [R18] seven-bit rate percent, software writes 1-100
// [R19] status bit 0 controller busy
// [R20] status bit 1 error, bit 2 check fail
// [R21] status bit 3 read generator busy
// [R22] bridge holds address until read valid
// [R23] write strobe one cycle with address, data
// [R24] unmapped reads zero, illegal writes ignored
// [R25] request and start are one-cycle pulses
`timescale 1ns/100ps
`default_nettype none

module user_register_block (
  input wire logic mclk,
  input wire logic reset_n,
  // register interface from the clock-crossing bus bridge
  input wire logic [15:0] reg_word_addr,
  input wire logic [31:0] reg_wr_data,
  input wire logic [3:0] reg_byte_write_mask,
  input wire logic reg_write_strobe,
  input wire logic reg_read_request,
  output logic [31:0] reg_rd_data,
  output logic reg_read_valid,
  // main user command toward the storage controller
  output logic [2:0] main_user_cmd_code,
  output logic single_cmd_request,
  input wire logic main_user_busy_flag,
  input wire logic main_user_error_flag,
  // read test generator
  output user_reg_pkg::gen_cfg_s read_gen_cfg,
  output logic read_gen_start,
  input wire logic read_gen_busy,
  input wire logic read_gen_check_fail,
  input wire logic [31:0] read_gen_rd_data,
  // secondary user and write test generator area
  output user_reg_pkg::sub_req_s write_gen_req,
  input wire logic [31:0] write_gen_rd_data,
  // identify data RAM read port
  output logic [10:0] identify_ram_addr,
  input wire logic [31:0] identify_ram_rd_data,
  // custom data RAM port
  output user_reg_pkg::sub_req_s custom_ram_req,
  input wire logic [31:0] custom_ram_rd_data,
  // custom command parameter area
  output user_reg_pkg::sub_req_s custom_param_req,
  input wire logic [31:0] custom_param_rd_data,
  // shared parameters, link status and version area
  output user_reg_pkg::sub_req_s shared_req,
  input wire logic [31:0] shared_rd_data
);

  typedef enum logic [2:0] {
    AREA_MAIN_CTRL,
    AREA_MAIN_STS,
    AREA_SUB,
    AREA_IDEN,
    AREA_CUST,
    AREA_CPARAM,
    AREA_SHARED,
    AREA_NONE
  } area_e;

  area_e area;
  logic wr_ok;
  logic [2:0] rd_pipe;
  area_e area_q;
  logic [31:0] local_q;
  logic [31:0] next_rd_data;
  logic [31:0] status_word;

  // area decode from upper bits of the word address
  // gaps such as 0x0400-0x1FFF fall to AREA_NONE: reads zero, writes vanish
  // ranges are compared as whole words so the decode needs no table
  always_comb begin
    area = AREA_NONE;
    if (reg_word_addr <= user_reg_pkg::MAIN_CTRL_HI) begin // [R1] [R5]
      area = AREA_MAIN_CTRL; // [R9]
    end else if (reg_word_addr <= user_reg_pkg::MAIN_STS_HI) begin
      area = AREA_MAIN_STS; // [R9]
    end else if (reg_word_addr <= user_reg_pkg::SUB_HI) begin
      area = AREA_SUB; // [R1]
    end else if (reg_word_addr >= user_reg_pkg::IDEN_LO &&
                 reg_word_addr <= user_reg_pkg::IDEN_HI) begin
      area = AREA_IDEN; // [R2]
    end else if (reg_word_addr >= user_reg_pkg::CUST_LO &&
                 reg_word_addr <= user_reg_pkg::CUST_HI) begin
      area = AREA_CUST; // [R3]
    end else if (reg_word_addr >= user_reg_pkg::CPARAM_LO &&
                 reg_word_addr <= user_reg_pkg::CPARAM_HI) begin
      area = AREA_CPARAM; // [R4]
    end else if (reg_word_addr >= user_reg_pkg::SHARED_LO) begin
      area = AREA_SHARED; // [R4]
    end
  end

  // the byte mask is never consulted: every write is a whole word
  assign wr_ok = reg_write_strobe; // [R6]

  // main-user control registers
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      read_gen_cfg.start_addr <= '0;
      read_gen_cfg.length <= '0;
      read_gen_cfg.pattern <= user_reg_pkg::PATT_INCR;
      read_gen_cfg.check_en <= 1'b0;
      read_gen_cfg.random_addr <= 1'b0;
      read_gen_cfg.rate <= user_reg_pkg::RST_RATE;
      main_user_cmd_code <= user_reg_pkg::CMD_IDENTIFY;
    end else if (wr_ok && area == AREA_MAIN_CTRL) begin
      case (reg_word_addr)
        user_reg_pkg::OFS_ADDR_LOW: begin
          read_gen_cfg.start_addr[31:0] <= reg_wr_data; // [R10]
        end
        user_reg_pkg::OFS_ADDR_HIGH: begin
          read_gen_cfg.start_addr[47:32] <= reg_wr_data[15:0]; // [R10]
        end
        user_reg_pkg::OFS_LEN_LOW: begin
          read_gen_cfg.length[31:0] <= reg_wr_data; // [R11]
        end
        user_reg_pkg::OFS_LEN_HIGH: begin
          read_gen_cfg.length[47:32] <= reg_wr_data[15:0]; // [R11]
        end
        user_reg_pkg::OFS_CMD: begin
          main_user_cmd_code <= reg_wr_data[2:0]; // [R12]
        end
        user_reg_pkg::OFS_PATT: begin
          read_gen_cfg.pattern <= reg_wr_data[2:0]; // [R15]
          read_gen_cfg.check_en <=
            reg_wr_data[user_reg_pkg::PATT_CHECK_BIT]; // [R16]
          read_gen_cfg.random_addr <=
            reg_wr_data[user_reg_pkg::PATT_RANDOM_BIT]; // [R17]
        end
        user_reg_pkg::OFS_RATE: begin
          // out-of-range values are stored as their low seven bits; software keeps 1-100
          read_gen_cfg.rate <= reg_wr_data[6:0]; // [R18]
        end
        default: begin
        end
      endcase
    end
  end

  // command pulses: one cycle, only on the command write itself
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      single_cmd_request <= 1'b0;
      read_gen_start <= 1'b0;
    end else begin
      single_cmd_request <= 1'b0; // [R25]
      read_gen_start <= 1'b0; // [R25]
      if (wr_ok && area == AREA_MAIN_CTRL &&
          reg_word_addr == user_reg_pkg::OFS_CMD) begin
        if (reg_wr_data[2:0] == user_reg_pkg::CMD_READ) begin
          read_gen_start <= 1'b1; // [R14]
        end else begin
          // reserved codes are passed on as well; the controller rejects them
          single_cmd_request <= 1'b1; // [R13]
        end
      end
    end
  end

  // forwarded requests toward the submodule areas (area base removed; write_gen_req takes the whole address)
  // addr and data follow the bus every cycle; only .wr/.rd qualify them
  // this toggles on idle cycles but keeps the decode one flop deep
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      write_gen_req <= '0;
      custom_ram_req <= '0;
      custom_param_req <= '0;
      shared_req <= '0;
      identify_ram_addr <= '0;
    end else begin
      write_gen_req.addr <= reg_word_addr; // [R7]
      write_gen_req.data <= reg_wr_data;
      write_gen_req.wr <= wr_ok && area == AREA_SUB; // [R1]
      write_gen_req.rd <= reg_read_request && area == AREA_SUB;
      custom_ram_req.addr <= reg_word_addr - user_reg_pkg::CUST_LO; // [R7]
      custom_ram_req.data <= reg_wr_data;
      custom_ram_req.wr <= wr_ok && area == AREA_CUST; // [R3]
      custom_ram_req.rd <= reg_read_request && area == AREA_CUST;
      custom_param_req.addr <= reg_word_addr - user_reg_pkg::CPARAM_LO;
      custom_param_req.data <= reg_wr_data;
      custom_param_req.wr <= wr_ok && area == AREA_CPARAM; // [R4]
      custom_param_req.rd <= reg_read_request && area == AREA_CPARAM;
      shared_req.addr <= reg_word_addr - user_reg_pkg::SHARED_LO;
      shared_req.data <= reg_wr_data;
      shared_req.wr <= wr_ok && area == AREA_SHARED; // [R4]
      shared_req.rd <= reg_read_request && area == AREA_SHARED;
      // identify RAM has no write path from here at all
      identify_ram_addr <= reg_word_addr[12:2]; // [R2]
    end
  end

  // status word, read only
  // flags come from logic on mclk, so no synchroniser is placed here
  always_comb begin
    status_word = user_reg_pkg::RST_WORD;
    status_word[user_reg_pkg::STS_BUSY_BIT] = main_user_busy_flag; // [R19]
    status_word[user_reg_pkg::STS_ERROR_BIT] = main_user_error_flag; // [R20]
    status_word[user_reg_pkg::STS_FAIL_BIT] = read_gen_check_fail; // [R20]
    status_word[user_reg_pkg::STS_GEN_BUSY_BIT] = read_gen_busy; // [R21]
  end

  // read valid: the request walks through three flops
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rd_pipe <= '0;
    end else begin
      rd_pipe <= {rd_pipe[1:0], reg_read_request}; // [R8]
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      reg_read_valid <= 1'b0;
    end else begin
      reg_read_valid <= rd_pipe[1]; // [R8]
    end
  end

  // first mux level: local status; address is held by the bridge
  // area_q and local_q follow the address every cycle; it must hold until
  // the edge after the request edge, or the returned data is corrupted
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      local_q <= '0;
      area_q <= AREA_NONE;
    end else begin
      area_q <= area; // [R22]
      if (area == AREA_MAIN_STS &&
          reg_word_addr == user_reg_pkg::OFS_STATUS) begin
        local_q <= status_word; // [R9]
      end else if (area == AREA_MAIN_STS) begin
        local_q <= read_gen_rd_data; // [R7]
      end else begin
        local_q <= '0; // [R24]
      end
    end
  end

  // second mux level: choose among submodule outputs
  always_comb begin
    case (area_q)
      AREA_MAIN_STS: next_rd_data = local_q; // [R7]
      AREA_SUB: next_rd_data = write_gen_rd_data;
      AREA_IDEN: next_rd_data = identify_ram_rd_data; // [R2]
      AREA_CUST: next_rd_data = custom_ram_rd_data; // [R3]
      AREA_CPARAM: next_rd_data = custom_param_rd_data; // [R4]
      AREA_SHARED: next_rd_data = shared_rd_data; // [R4]
      default: next_rd_data = '0; // [R24]
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      reg_rd_data <= '0;
    end else if (rd_pipe[1]) begin
      reg_rd_data <= next_rd_data; // [R7]
    end
  end

endmodule

`default_nettype wire
